// [mcps_top.sv]
`timescale 1ns/1ns
// How it works
// R01 - A write to address 11 fires a pulse on the pulse output pin.
// R02 - Data written to the strobe address is ignored and changes nothing.
// R03 - The pulse is active low and one clock long per write.
// R04 - Mode bits 8, 9 and 12 to 15 are zero after reset.
// R05 - Mode bits 0 to 7 read the mask revision; writes ignored.
// R06 - Mode bit 8 holds the device in static power-down.
// R07 - Mode bit 9 turns off clock-loss detection; host should keep it zero.
// R08 - Mode bits 10 and 11 read high, low when powered down.
// R09 - Mode bit 12 inverts the top bit of channel A outputs.
// R10 - Mode bit 13 inverts the top bit of channel B outputs.
// R11 - Mode bit 14 inverts the top bit of channel A inputs.
// R12 - Mode bit 15 inverts the top bit of channel B inputs.
// R13 - Host sets input inversion for offset-binary input channels.
// R14 - Host sets output inversion where offset-binary results are wanted.
module mcps_top
  import mcps_pkg::*;
#(
  parameter int IN_W = 12,
  parameter int OUT_W = 16,
  parameter logic [7:0] MASK_REV = 8'h5a, // Arbitrary value
  parameter int CLKLOSS_CYCLES = CLKLOSS_CYC
) (
  input wire logic sys_clk, // 50 MHz clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic [3:0] addr, // Register address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata_ff, // Read data, cycle after rd
  input wire logic clk_alive, // Clock-activity pin, toggles
  input wire logic [IN_W-1:0] in_a, // Channel A input sample
  input wire logic [IN_W-1:0] in_b, // Channel B input sample
  input wire logic [OUT_W-1:0] res_a, // Channel A result
  input wire logic [OUT_W-1:0] res_b, // Channel B result
  output logic [IN_W-1:0] proc_a_ff, // Channel A to filter
  output logic [IN_W-1:0] proc_b_ff, // Channel B to filter
  output logic [OUT_W-1:0] out_a_ff, // Channel A output
  output logic [OUT_W-1:0] out_b_ff, // Channel B output
  output logic pulse_output_pin_n_ff, // Pulse pin, active low
  output logic powered_down_ff, // Processing halted
  output logic irq_ff // Interrupt level
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  mcps_bus_s bus;
  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  wire hit_strobe = bus.addr == OFS_STROBE;
  wire hit_mode = bus.addr == OFS_MODE;
  wire hit_stat = bus.addr == OFS_IRQ_STAT;
  wire hit_mask = bus.addr == OFS_IRQ_MASK;
  wire wr_strobe = ce && bus.wr && hit_strobe;
  wire wr_mode = ce && bus.wr && hit_mode;
  wire wr_stat = ce && bus.wr && hit_stat;
  wire wr_mask = ce && bus.wr && hit_mask;

  // ----------------------------------------
  // Mode control
  // ----------------------------------------
  mcps_ctrl_s ctrl_ff;
  mcps_ctrl_s nxt_ctrl;
  assign nxt_ctrl = '{pwrdn: bus.wdata[MODE_PWRDN],
                      no_clkloss: bus.wdata[MODE_NO_CLKLOSS],
                      flip_out_a: bus.wdata[MODE_FLIP_OUT_A],
                      flip_out_b: bus.wdata[MODE_FLIP_OUT_B],
                      flip_in_a: bus.wdata[MODE_FLIP_IN_A],
                      flip_in_b: bus.wdata[MODE_FLIP_IN_B]};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= MODE_CTRL_RST; // R04
    end else if (wr_mode) begin
      ctrl_ff <= nxt_ctrl; // R05
    end
  end

  // ----------------------------------------
  // Clock-loss detection
  // ----------------------------------------
  // Pin is asynchronous: two-stage synchroniser before any use
  logic alive_s1_ff;
  logic alive_s2_ff;
  logic alive_s3_ff;
  logic [15:0] quiet_cnt_ff;
  logic clkloss_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alive_s1_ff <= 1'b0;
      alive_s2_ff <= 1'b0;
      alive_s3_ff <= 1'b0;
    end else if (ce) begin
      alive_s1_ff <= clk_alive;
      alive_s2_ff <= alive_s1_ff;
      alive_s3_ff <= alive_s2_ff;
    end
  end

  wire alive_edge = alive_s2_ff ^ alive_s3_ff;
  wire quiet_full = quiet_cnt_ff == 16'(CLKLOSS_CYCLES - 1);
  wire [15:0] nxt_quiet = (alive_edge || ctrl_ff.no_clkloss) ? 16'h0000 :
                          quiet_full ? quiet_cnt_ff : quiet_cnt_ff + 16'h0001;
  // Detection clears again once activity returns
  wire nxt_clkloss = !ctrl_ff.no_clkloss && quiet_full && !alive_edge; // R07

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet_cnt_ff <= 16'h0000;
      clkloss_ff <= 1'b0;
    end else if (ce) begin
      quiet_cnt_ff <= nxt_quiet;
      clkloss_ff <= nxt_clkloss;
    end
  end

  // ----------------------------------------
  // Power-down and pulse
  // ----------------------------------------
  wire nxt_pdn = ctrl_ff.pwrdn || clkloss_ff; // R06
  wire nxt_pulse_n = !wr_strobe; // R01 R02 R03

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      powered_down_ff <= 1'b0;
      pulse_output_pin_n_ff <= 1'b1;
    end else if (ce) begin
      powered_down_ff <= nxt_pdn;
      pulse_output_pin_n_ff <= nxt_pulse_n; // R03
    end
  end

  // ----------------------------------------
  // Data paths
  // ----------------------------------------
  mcps_msb_flip #(.W(IN_W)) u_in_a (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .hold(powered_down_ff),
    .flip(ctrl_ff.flip_in_a), .din(in_a), .dout_ff(proc_a_ff) // R11
  );
  mcps_msb_flip #(.W(IN_W)) u_in_b (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .hold(powered_down_ff),
    .flip(ctrl_ff.flip_in_b), .din(in_b), .dout_ff(proc_b_ff) // R12
  );
  mcps_msb_flip #(.W(OUT_W)) u_out_a (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .hold(powered_down_ff),
    .flip(ctrl_ff.flip_out_a), .din(res_a), .dout_ff(out_a_ff) // R09
  );
  mcps_msb_flip #(.W(OUT_W)) u_out_b (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .hold(powered_down_ff),
    .flip(ctrl_ff.flip_out_b), .din(res_b), .dout_ff(out_b_ff) // R10
  );

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [2:0] stat_ff;
  logic [2:0] mask_ff;
  logic pdn_d_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pdn_d_ff <= 1'b0;
    end else if (ce) begin
      pdn_d_ff <= powered_down_ff;
    end
  end

  wire [2:0] irq_evt = {powered_down_ff && !pdn_d_ff, nxt_clkloss && !clkloss_ff, wr_strobe};
  wire [2:0] stat_clr = wr_stat ? bus.wdata[2:0] : 3'h0;
  // Set beats clear in the same cycle
  wire [2:0] nxt_stat = (stat_ff & ~stat_clr) | irq_evt;
  wire nxt_irq = |(nxt_stat & mask_ff);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_ff <= IRQ_RST;
      mask_ff <= IRQ_RST;
      irq_ff <= 1'b0;
    end else if (ce) begin
      stat_ff <= nxt_stat;
      irq_ff <= nxt_irq;
      if (wr_mask) begin
        mask_ff <= bus.wdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  wire [1:0] pdn_stat = {2{!powered_down_ff}}; // R08
  wire [15:0] mode_rd = {ctrl_ff.flip_in_b, ctrl_ff.flip_in_a, ctrl_ff.flip_out_b,
                         ctrl_ff.flip_out_a, pdn_stat, ctrl_ff.no_clkloss,
                         ctrl_ff.pwrdn, MASK_REV}; // R05
  // Strobe address is write-only and reads zero, like unmapped space
  wire [15:0] nxt_rdata = !bus.rd ? 16'h0000 :
                          hit_mode ? mode_rd :
                          hit_stat ? {13'h0000, stat_ff} :
                          hit_mask ? {13'h0000, mask_ff} : 16'h0000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

endmodule

// [mcps_pkg.sv]
package mcps_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFS_STROBE = 4'hb;
  localparam logic [3:0] OFS_MODE = 4'hc;
  localparam logic [3:0] OFS_IRQ_STAT = 4'hd;
  localparam logic [3:0] OFS_IRQ_MASK = 4'he;

  // ----------------------------------------
  // Mode register fields
  // ----------------------------------------
  localparam int MODE_REV_LSB = 0;
  localparam int MODE_REV_W = 8;
  localparam int MODE_PWRDN = 8;
  localparam int MODE_NO_CLKLOSS = 9;
  localparam int MODE_STAT_LO = 10;
  localparam int MODE_STAT_HI = 11;
  localparam int MODE_FLIP_OUT_A = 12;
  localparam int MODE_FLIP_OUT_B = 13;
  localparam int MODE_FLIP_IN_A = 14;
  localparam int MODE_FLIP_IN_B = 15;
  localparam logic [5:0] MODE_CTRL_RST = 6'h00;

  // ----------------------------------------
  // Interrupt status bits
  // ----------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_PULSE = 0;
  localparam int IRQ_CLKLOSS = 1;
  localparam int IRQ_PWRDN = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int CLKLOSS_NS = 1000;
  localparam int CLKLOSS_CYC = (CLKLOSS_NS * CLK_MHZ) / 1000;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } mcps_bus_s;

  typedef struct packed {
    logic pwrdn;
    logic no_clkloss;
    logic flip_out_a;
    logic flip_out_b;
    logic flip_in_a;
    logic flip_in_b;
  } mcps_ctrl_s;

endpackage

// [mcps_msb_flip.sv]
`timescale 1ns/1ns
// Registered top-bit inversion with hold during power-down
module mcps_msb_flip #(
  parameter int W = 16
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic ce, // Clock enable
  input wire logic hold, // Freeze while powered down
  input wire logic flip, // Invert top bit
  input wire logic [W-1:0] din, // Sample in
  output logic [W-1:0] dout_ff // Sample out
);

  wire [W-1:0] nxt_dout = {din[W-1] ^ flip, din[W-2:0]};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dout_ff <= '0;
    end else if (ce && !hold) begin
      dout_ff <= nxt_dout;
    end
  end

endmodule

// [mcps_top_asserts.sv]
`timescale 1ns/1ns
module mcps_top_asserts
  import mcps_pkg::*;
#(
  parameter int IN_W = 12,
  parameter int OUT_W = 16,
  parameter logic [7:0] MASK_REV = 8'h5a
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Enable
  input wire logic [3:0] addr, // Address
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [15:0] rdata_ff, // Read data
  input wire logic [IN_W-1:0] in_a, // Input A
  input wire logic [OUT_W-1:0] res_a, // Result A
  input wire logic [IN_W-1:0] proc_a_ff, // To filter A
  input wire logic [OUT_W-1:0] out_a_ff, // Output A
  input wire logic pulse_output_pin_n_ff, // Pulse pin
  input wire logic powered_down_ff // Halted
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_strobe; ce && wr && addr == OFS_STROBE; endsequence
  sequence s_rdmode; ce && rd && addr == OFS_MODE; endsequence
  property p_pulse; s_strobe |=> !pulse_output_pin_n_ff; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse missing");
  property p_one; !pulse_output_pin_n_ff && $past(ce) |-> $past(wr && addr == OFS_STROBE);
  endproperty
  a_one: assert property (p_one) else $error("pulse without write");
  property p_wo; ce && rd && addr == OFS_STROBE |=> rdata_ff == 16'h0000; endproperty
  a_wo: assert property (p_wo) else $error("strobe address readable");
  property p_rev; s_rdmode |=> rdata_ff[7:0] == MASK_REV; endproperty
  a_rev: assert property (p_rev) else $error("revision wrong");
  property p_stat; s_rdmode |=> rdata_ff[11:10] == {2{!$past(powered_down_ff)}}; endproperty
  a_stat: assert property (p_stat) else $error("status bits wrong");
  property p_hold; powered_down_ff |=> $stable(out_a_ff); endproperty
  a_hold: assert property (p_hold) else $error("output moved in power-down");
  property p_pa; ce && !powered_down_ff |=> proc_a_ff[IN_W-2:0] == $past(in_a[IN_W-2:0]);
  endproperty
  a_pa: assert property (p_pa) else $error("input A low bits wrong");
  property p_oa; ce && !powered_down_ff |=> out_a_ff[OUT_W-2:0] == $past(res_a[OUT_W-2:0]);
  endproperty
  a_oa: assert property (p_oa) else $error("output A low bits wrong");
endmodule

// [mcps_host.sv]
`timescale 1ns/1ns
module mcps_host
  import mcps_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic [15:0] rdata_ff, // Read data
  output mcps_bus_s bus // Register port
);
  initial bus = '0;
  task automatic put(input logic [3:0] a, input logic [15:0] d, input logic w);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
  endtask
  // Released address and data lines show inverted values; wr and rd are driven low
  task automatic idle(output logic [15:0] q);
    @(posedge sys_clk);
    bus <= '{addr: ~bus.addr, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b0};
    #1 q = rdata_ff;
  endtask
  task automatic set_formats(input logic in_ob, input logic out_ob);
    logic [15:0] q;
    put(OFS_MODE, {{2{in_ob}}, {2{out_ob}}, 12'h0000}, 1'b1);
    idle(q);
  endtask
endmodule

// [mcps_top_tb.sv]
`timescale 1ns/1ns
module mcps_top_tb;
  import mcps_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic alive = 1'b1;
  logic clk_alive = 1'b0;
  logic [11:0] in_a = 12'h0123;
  logic [11:0] in_b = 12'h0456;
  logic [15:0] res_a = 16'h1234;
  logic [15:0] res_b = 16'h5678;
  logic [11:0] proc_a, proc_b;
  logic [15:0] rdata, out_a, out_b, q;
  logic pulse_n, pd, irq;
  mcps_bus_s bus;
  int miscompares = 0;
  int total_checks = 0;
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (alive) clk_alive <= ~clk_alive;
  mcps_host mcps_host_inst(.sys_clk(sys_clk), .rdata_ff(rdata), .bus(bus));
  mcps_top #(.CLKLOSS_CYCLES(8)) mcps_top_inst(.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata_ff(rdata),
    .clk_alive(clk_alive), .in_a(in_a), .in_b(in_b), .res_a(res_a), .res_b(res_b),
    .proc_a_ff(proc_a), .proc_b_ff(proc_b), .out_a_ff(out_a), .out_b_ff(out_b),
    .pulse_output_pin_n_ff(pulse_n), .powered_down_ff(pd), .irq_ff(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    mcps_host_inst.put(a, 16'h0000, 1'b0);
    mcps_host_inst.idle(d);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    mcps_host_inst.put(a, d, 1'b1);
    mcps_host_inst.idle(q);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(OFS_MODE, q);
    chk("mode", 16'h0c5a, q);
    chk("pin", 16'h0001, {15'h0000, pulse_n});
  endtask
  task automatic t_strobe;
    mcps_host_inst.put(OFS_STROBE, 16'hffff, 1'b1);
    mcps_host_inst.put(OFS_STROBE, 16'h0000, 1'b1);
    mcps_host_inst.idle(q);
    chk("pin", 16'h0000, {15'h0000, pulse_n});
    wait_cyc(1);
    chk("pin", 16'h0001, {15'h0000, pulse_n});
    rd(OFS_STROBE, q);
    chk("strobe", 16'h0000, q);
    rd(OFS_MODE, q);
    chk("mode", 16'h0c5a, q);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(OFS_IRQ_MASK, 16'h0001);
    wait_cyc(1);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(OFS_IRQ_STAT, 16'h0001);
    wait_cyc(1);
    chk("irq", 16'h0000, {15'h0000, irq});
  endtask
  task automatic t_flip;
    wr(OFS_MODE, 16'hf0ff);
    rd(OFS_MODE, q);
    chk("mode", 16'hfc5a, q);
    chk("proc_a", 16'h0923, {4'h0, proc_a});
    chk("proc_b", 16'h0c56, {4'h0, proc_b});
    chk("out_a", 16'h9234, out_a);
    chk("out_b", 16'hd678, out_b);
    mcps_host_inst.set_formats(1'b0, 1'b0);
  endtask
  task automatic t_pwrdn;
    wr(OFS_MODE, 16'h0100);
    rd(OFS_MODE, q);
    chk("mode", 16'h015a, q);
    chk("pd", 16'h0001, {15'h0000, pd});
    @(posedge sys_clk);
    in_a <= 12'h0fff;
    wait_cyc(2);
    chk("proc_a", 16'h0123, {4'h0, proc_a});
    wr(OFS_MODE, 16'h0000);
    wait_cyc(3);
    chk("proc_a", 16'h0fff, {4'h0, proc_a});
    rd(OFS_IRQ_STAT, q);
    chk("stat", 16'h0004, q);
    wr(OFS_IRQ_STAT, 16'h0004);
  endtask
  task automatic t_loss;
    wr(OFS_MODE, 16'h0200);
    alive <= 1'b0;
    wait_cyc(20);
    chk("pd", 16'h0000, {15'h0000, pd});
    wr(OFS_MODE, 16'h0000);
    wait_cyc(20);
    chk("pd", 16'h0001, {15'h0000, pd});
    rd(OFS_MODE, q);
    chk("mode", 16'h005a, q);
    rd(OFS_IRQ_STAT, q);
    chk("stat", 16'h0006, q);
    wr(OFS_IRQ_MASK, 16'h0006);
    wait_cyc(1);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(OFS_IRQ_STAT, 16'h0006);
    wait_cyc(1);
    chk("irq", 16'h0000, {15'h0000, irq});
    alive <= 1'b1;
    wait_cyc(10);
    chk("pd", 16'h0000, {15'h0000, pd});
  endtask
  // Clock enable low must swallow both a strobe and a mode write
  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(OFS_STROBE, 16'h0000);
    chk("pin", 16'h0001, {15'h0000, pulse_n});
    wr(OFS_MODE, 16'h0100);
    wait_cyc(2);
    chk("pd", 16'h0000, {15'h0000, pd});
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(OFS_MODE, q);
    chk("mode", 16'h0c5a, q);
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_strobe;
    t_flip;
    t_pwrdn;
    t_loss;
    t_freeze;
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    wrap_up;
  end
endmodule
bind mcps_top mcps_top_asserts #(.IN_W(IN_W), .OUT_W(OUT_W), .MASK_REV(MASK_REV))
  mcps_top_asserts_inst(.sys_clk(sys_clk), .rst(rst), .ce(ce), .addr(addr), .wr(wr),
  .rd(rd), .rdata_ff(rdata_ff), .in_a(in_a), .res_a(res_a), .proc_a_ff(proc_a_ff),
  .out_a_ff(out_a_ff), .pulse_output_pin_n_ff(pulse_output_pin_n_ff),
  .powered_down_ff(powered_down_ff));
